// ==== src/txfsv_pkg.sv ====
// ============================================================
// shared constants and carriers for the transmit statistics block
package txfsv_pkg;

  // ============================================================
  // statistics vector field positions
  localparam int VEC_W_BASE    = 26;
  localparam int VEC_W_PFC     = 27;
  localparam int BIT_SUCCESS   = 0;
  localparam int BIT_BCAST     = 1;
  localparam int BIT_MCAST     = 2;
  localparam int BIT_UNDERRUN  = 3;
  localparam int BIT_CTRL      = 4;
  localparam int LEN_LSB       = 5;
  localparam int LEN_W         = 15;
  localparam int BIT_VLAN      = 20;
  localparam int BV_LSB        = 21;
  localparam int BV_W          = 4;
  localparam int BIT_PAUSE     = 25;
  localparam int BIT_PFC       = 26;

  // ============================================================
  // frame content constants
  localparam logic [14:0] LEN_MAX       = 15'h7FFF;
  localparam logic [15:0] TYPE_MAC_CTRL = 16'h8808;
  localparam logic [15:0] TYPE_VLAN     = 16'h8100;
  localparam logic [47:0] ADDR_BCAST    = 48'hFFFF_FFFF_FFFF;
  localparam logic [3:0]  BEAT_BYTES    = 4'h8;

  // ============================================================
  // register map (byte addresses) and reset values
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_MASK      = 8'h08;
  localparam logic [7:0]  REG_LAST_VEC  = 8'h0C;
  localparam logic [7:0]  REG_FRAME_CNT = 8'h10;
  localparam logic [0:0]  CTRL_RST      = 1'h0;
  localparam logic [2:0]  MASK_RST      = 3'h0;
  localparam int          CTRL_VLAN_EN  = 0;
  localparam int          ST_FRAME_DONE = 0;
  localparam int          ST_UNDERRUN   = 1;
  localparam int          ST_PAUSE      = 2;
  localparam int          ST_W          = 3;

  // ============================================================
  // one beat of the outgoing frame as it leaves toward the phy
  typedef struct packed {
    logic        valid;      // beat carries frame bytes
    logic        first;      // first beat of frame
    logic        last;       // last beat of frame
    logic [3:0]  bytes;      // bytes in this beat, 1..8
    logic [63:0] data;       // byte 0 in bits 7:0
    logic        underrun;   // frame cut short by underrun
    logic        pause_sent; // frame is a pause frame raised by pause request
    logic        pfc_sent;   // frame is a generated pfc frame
  } txfsv_beat_s;

  // per-frame summary
  typedef struct packed {
    logic        pfc;
    logic        pause;
    logic        vlan;
    logic [14:0] length;
    logic        ctrl;
    logic        underrun;
    logic        mcast;
    logic        bcast;
    logic        success;
  } txfsv_flags_s;

  typedef enum logic [2:0] {
    TXFSV_IDLE = 3'b001,
    TXFSV_HDR  = 3'b010,
    TXFSV_BODY = 3'b100
  } txfsv_state_e;

endpackage

// ==== src/txfsv_parser.sv ====
// ============================================================
// frame parser: gathers per-frame flags and length from beats
module txfsv_parser
  import txfsv_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  // control
  input  wire logic         vlan_en_in,
  // beat stream
  input  wire txfsv_beat_s  beat_in,
  // frame summary
  output txfsv_flags_s      flags_out,
  output logic              done_out
);

  txfsv_state_e state;
  txfsv_state_e next_state;
  txfsv_flags_s acc;
  txfsv_flags_s next_acc;
  txfsv_flags_s next_flags;
  logic         next_done;
  logic [15:0]  sum;
  logic [15:0]  ltype;

  // ============================================================
  // next state of the accumulators
  always_comb
  begin
    next_state = state;
    next_acc   = acc;
    next_flags = flags_out;
    next_done  = 1'b0;
    ltype      = {beat_in.data[39:32], beat_in.data[47:40]};
    sum        = 16'h0000;
    if (beat_in.valid)
    begin
      if (beat_in.first)
      begin
        next_acc          = '0;
        next_acc.mcast    = beat_in.data[0];
        next_acc.bcast    = beat_in.data[47:0] == ADDR_BCAST;
        next_acc.length   = {11'h000, beat_in.bytes};
        next_state        = TXFSV_HDR;
      end
      else
      begin
        // length saturates rather than wrapping on jumbo frames
        sum            = {1'b0, acc.length} + {12'h000, beat_in.bytes};
        next_acc.length = sum[15] ? LEN_MAX : sum[14:0];
        if (state == TXFSV_HDR)
        begin
          next_acc.ctrl = ltype == TYPE_MAC_CTRL;
          next_acc.vlan = (ltype == TYPE_VLAN) && vlan_en_in;
          next_state    = TXFSV_BODY;
        end
      end
      next_acc.underrun = next_acc.underrun | beat_in.underrun;
      next_acc.pause    = next_acc.pause | beat_in.pause_sent;
      next_acc.pfc      = next_acc.pfc | beat_in.pfc_sent;
      if (beat_in.last)
      begin
        next_flags         = next_acc;
        next_flags.success = ~next_acc.underrun;
        next_done          = 1'b1;
        next_state         = TXFSV_IDLE;
      end
    end
  end

  // ============================================================
  // register the accumulators
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state     <= TXFSV_IDLE;
      acc       <= '0;
      flags_out <= '0;
      done_out  <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      acc       <= next_acc;
      flags_out <= next_flags;
      done_out  <= next_done;
    end
  end

endmodule

// ==== src/txfsv_top.sv ====
// ============================================================
// transmit statistics vector with ahb-lite register access

// What this block does
// - The statistics bus is 26 bits wide, or 27 bits when priority flow control is built in.
// - The bus is driven on the core clock after each sent frame, its flags meaningful only with the valid strobe.
// - The last-beat byte count field is meaningful on every clock cycle regardless of the strobe.
// - The last-beat byte count gives the frame bytes sent in the latest cycle, from 0 to 8.
// - The byte count is taken from an earlier pipeline point than the flags, so users must not align them.
// - With priority flow control built in, the top bit marks a generated and sent pfc frame.
// - The pause bit marks a previous frame that was a pause frame raised by the pause request.
// - The tagged bit marks a previous frame carrying a vlan type while vlan handling is enabled.
// - The length field gives the previous frame's phy-side length with pad and fcs, saturating at 32767.
// - The control bit marks a previous frame whose type field held 88-08.
// - The underrun bit marks a previous frame cut short by underrun.
// - The multicast bit marks a previous frame with a multicast destination.
// - The broadcast bit marks a previous frame with the broadcast destination.
// - The success bit marks a previous frame sent without error.
module txfsv_top
  import txfsv_pkg::*;
#(
  parameter bit PFC_EN = 1'b0,
  parameter int VEC_W  = PFC_EN ? VEC_W_PFC : VEC_W_BASE
)
(
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  // ahb-lite slave
  input  wire logic         hsel_in,
  input  wire logic [31:0]  haddr_in,
  input  wire logic [1:0]   htrans_in,
  input  wire logic         hwrite_in,
  input  wire logic [2:0]   hsize_in,
  input  wire logic         hready_in,
  input  wire logic [31:0]  hwdata_in,
  output logic [31:0]       hrdata_out,
  output logic              hreadyout_out,
  output logic              hresp_out,
  // transmit beat stream from the transmitter
  input  wire txfsv_beat_s  tx_beat_in,
  // statistics outputs
  output logic [VEC_W-1:0]  tx_stats_vector_out,
  output logic              tx_stats_valid_out,
  // interrupt
  output logic              irq_out
);

  txfsv_flags_s      flags;
  logic              done;
  logic              vlan_en;
  logic [ST_W-1:0]   status;
  logic [ST_W-1:0]   mask;
  logic [31:0]       frame_cnt;
  logic [VEC_W-1:0]  last_vec;
  logic              dp_act;
  logic              dp_write;
  logic [7:0]        dp_addr;

  logic              next_vlan_en;
  logic [ST_W-1:0]   next_status;
  logic [ST_W-1:0]   next_mask;
  logic [31:0]       next_frame_cnt;
  logic [VEC_W-1:0]  next_last_vec;
  logic [VEC_W-1:0]  next_vec;
  logic              next_valid;
  logic              next_irq;
  logic              next_dp_act;
  logic              next_dp_write;
  logic [7:0]        next_dp_addr;
  logic [31:0]       next_hrdata;
  logic              next_hreadyout;
  logic [ST_W-1:0]   ev;
  logic [ST_W-1:0]   rd_clr;
  logic [31:0]       rd_val;

  // ============================================================
  // frame parser
  txfsv_parser u_parser (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .vlan_en_in  (vlan_en),
    .beat_in     (tx_beat_in),
    .flags_out   (flags),
    .done_out    (done)
  );

  // ============================================================
  // statistics vector assembly
  always_comb
  begin
    next_vec   = tx_stats_vector_out;
    next_valid = done;
    // byte count tracks the raw beat, one stage ahead of the flags
    next_vec[BV_LSB +: BV_W] = tx_beat_in.valid ? tx_beat_in.bytes : 4'h0;
    if (done)
    begin
      next_vec[BIT_SUCCESS]         = flags.success;
      next_vec[BIT_BCAST]           = flags.bcast;
      next_vec[BIT_MCAST]           = flags.mcast;
      next_vec[BIT_UNDERRUN]        = flags.underrun;
      next_vec[BIT_CTRL]            = flags.ctrl;
      next_vec[LEN_LSB +: LEN_W]    = flags.length;
      next_vec[BIT_VLAN]            = flags.vlan;
      next_vec[BIT_PAUSE]           = flags.pause;
      // index folds to the pause bit without pfc, so that bit is never overwritten
      if (PFC_EN)
      begin
        next_vec[PFC_EN ? BIT_PFC : BIT_PAUSE] = PFC_EN ? flags.pfc : flags.pause;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_stats_vector_out <= '0;
      tx_stats_valid_out  <= 1'b0;
    end
    else
    begin
      tx_stats_vector_out <= next_vec;
      tx_stats_valid_out  <= next_valid;
    end
  end

  // ============================================================
  // ahb-lite slave: one wait state, data answered from a flop
  always_comb
  begin
    next_dp_act    = 1'b0;
    next_dp_write  = dp_write;
    next_dp_addr   = dp_addr;
    next_hreadyout = 1'b1;
    next_hrdata    = hrdata_out;
    rd_val         = 32'h0000_0000;
    unique case (dp_addr)
      REG_CTRL:      rd_val = {31'h0000_0000, vlan_en};
      REG_STATUS:    rd_val = {29'h0000_0000, status};
      REG_MASK:      rd_val = {29'h0000_0000, mask};
      REG_LAST_VEC:  rd_val = 32'(last_vec);
      REG_FRAME_CNT: rd_val = frame_cnt;
      default:       rd_val = 32'h0000_0000;  // unmapped reads as zero
    endcase
    if (dp_act)
    begin
      next_hrdata = dp_write ? 32'h0000_0000 : rd_val;
    end
    else if (hsel_in && htrans_in[1] && hready_in)
    begin
      // accept address phase, stall the data phase one cycle
      next_dp_act    = 1'b1;
      next_dp_write  = hwrite_in;
      next_dp_addr   = {haddr_in[7:2], 2'b00};
      next_hreadyout = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dp_act        <= 1'b0;
      dp_write      <= 1'b0;
      dp_addr       <= 8'h00;
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
    else
    begin
      dp_act        <= next_dp_act;
      dp_write      <= next_dp_write;
      dp_addr       <= next_dp_addr;
      hrdata_out    <= next_hrdata;
      hreadyout_out <= next_hreadyout;
      hresp_out     <= 1'b0;              // always okay
    end
  end

  // ============================================================
  // control, status, mask and counters
  always_comb
  begin
    next_vlan_en   = vlan_en;
    next_mask      = mask;
    next_frame_cnt = frame_cnt;
    next_last_vec  = last_vec;
    ev             = '0;
    rd_clr         = '0;
    if (done)
    begin
      ev[ST_FRAME_DONE] = 1'b1;
      ev[ST_UNDERRUN]   = flags.underrun;
      ev[ST_PAUSE]      = flags.pause;
      next_frame_cnt    = frame_cnt + 32'h0000_0001;
    end
    if (next_valid)
    begin
      next_last_vec = next_vec;
    end
    if (dp_act && dp_write)
    begin
      if (dp_addr == REG_CTRL)
      begin
        next_vlan_en = hwdata_in[CTRL_VLAN_EN];
      end
      if (dp_addr == REG_MASK)
      begin
        next_mask = hwdata_in[ST_W-1:0];
      end
    end
    if (dp_act && !dp_write && dp_addr == REG_STATUS)
    begin
      rd_clr = '1;
    end
    // a new event in the clearing cycle survives
    next_status = (status & ~rd_clr) | ev;
    next_irq    = |(next_status & mask);
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      vlan_en   <= CTRL_RST;
      mask      <= MASK_RST;
      status    <= '0;
      frame_cnt <= 32'h0000_0000;
      last_vec  <= '0;
      irq_out   <= 1'b0;
    end
    else
    begin
      vlan_en   <= next_vlan_en;
      mask      <= next_mask;
      status    <= next_status;
      frame_cnt <= next_frame_cnt;
      last_vec  <= next_last_vec;
      irq_out   <= next_irq;
    end
  end

endmodule

// ==== verification/txfsv_monitor.sv ====
// ============================================================
// checker on the statistics outputs
module txfsv_monitor
  import txfsv_pkg::*;
#(
  parameter bit PFC_EN = 1'b0,
  parameter int VEC_W  = 26
)
(
  // clock and reset
  input logic              core_clk_in,
  input logic              rst_in,
  // watched ports
  input txfsv_beat_s       tx_beat_in,
  input logic [VEC_W-1:0]  tx_stats_vector_out,
  input logic              tx_stats_valid_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // ============================================================
  // field views
  logic [3:0] bv;
  logic       vld;
  assign bv  = tx_stats_vector_out[BV_LSB+:BV_W];
  assign vld = tx_stats_valid_out;

  AST_PULSE_CAUSE: assert property (vld |-> $past(tx_beat_in.valid && tx_beat_in.last, 2))
    else $error("statistics strobe without a frame end two cycles before");
  AST_BYTES_FOLLOW: assert property (bv == $past(tx_beat_in.valid ? tx_beat_in.bytes : 4'h0))
    else $error("byte count does not follow the previous beat");
  AST_BYTES_MAX: assert property (bv <= BEAT_BYTES)
    else $error("byte count above eight");
  AST_FLAGS_HOLD: assert property (!vld |-> $stable({tx_stats_vector_out[VEC_W-1:BV_LSB+BV_W],
                                                    tx_stats_vector_out[BV_LSB-1:0]}))
    else $error("flag fields moved without the strobe");
  AST_SUCCESS: assert property (vld |-> tx_stats_vector_out[BIT_SUCCESS] != tx_stats_vector_out[BIT_UNDERRUN])
    else $error("success flag not the inverse of underrun");
  AST_UNDERRUN: assert property (vld && $past(tx_beat_in.underrun, 2) |-> tx_stats_vector_out[BIT_UNDERRUN])
    else $error("underrun frame not flagged");
  AST_PAUSE: assert property (vld && $past(tx_beat_in.pause_sent, 2) |-> tx_stats_vector_out[BIT_PAUSE])
    else $error("pause frame not flagged");
  AST_BCAST_MCAST: assert property (vld && tx_stats_vector_out[BIT_BCAST] |-> tx_stats_vector_out[BIT_MCAST])
    else $error("broadcast frame not also multicast");
  AST_LEN_MIN: assert property (vld |-> tx_stats_vector_out[LEN_LSB+:LEN_W] >= $past(tx_beat_in.bytes, 2))
    else $error("length below the bytes of the last beat");
endmodule

bind txfsv_top txfsv_monitor #(.PFC_EN(PFC_EN), .VEC_W(VEC_W)) i_mon (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .tx_beat_in(tx_beat_in),
  .tx_stats_vector_out(tx_stats_vector_out), .tx_stats_valid_out(tx_stats_valid_out));

// ==== verification/txfsv_client.sv ====
// ============================================================
// client logic: counts frames and sums bytes per cycle
module txfsv_client
  import txfsv_pkg::*;
#(
  parameter int VEC_W = 27
)
(
  // clock and reset
  input  logic              core_clk_in,
  input  logic              rst_in,
  // statistics from the block
  input  logic [VEC_W-1:0]  vec_in,
  input  logic              valid_in,
  // totals
  output logic [31:0]       frames_out,
  output logic [31:0]       bytes_out
);
  // byte count taken every cycle, never aligned to the strobe
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      frames_out <= 32'h0;
      bytes_out  <= 32'h0;
    end
    else
    begin
      frames_out <= frames_out + {31'h0, valid_in};
      bytes_out  <= bytes_out + {28'h0, vec_in[BV_LSB+:BV_W]};
    end
  end
endmodule

// ==== verification/tb.sv ====
// ============================================================
// bench for the transmit statistics block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import txfsv_pkg::*;

  // frame row: underrun, pause, pfc in fx; expected flags in fl
  typedef struct packed {
    logic [47:0] da;
    logic [15:0] ty;
    logic [15:0] nb;
    logic [3:0]  lb;
    logic [2:0]  fx;
    logic [7:0]  fl;
  } txfsv_row_s;

  logic        clk;
  logic        rst    = 1'b1;
  logic        hsel   = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr  = 32'h0;
  logic [31:0] hwdata = 32'h0;
  txfsv_beat_s beat   = '0;
  logic        hrdy;
  logic        hresp;
  logic        vld;
  logic        irq;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] frames;
  logic [31:0] nbytes;
  logic [26:0] vec;
  int          num_errors;
  int          total_checks;
  int          nfr;
  int          sent;
  txfsv_row_s  rows [7] = '{
    '{48'h4433_2211_0002, 16'h0800, 16'h8, 4'h4, 3'h0, 8'h01},
    '{48'hFFFF_FFFF_FFFF, 16'h0800, 16'h8, 4'h8, 3'h0, 8'h07},
    '{48'h0000_0000_0001, 16'h8808, 16'h8, 4'h4, 3'h2, 8'h55},
    '{48'h4433_2211_0002, 16'h0800, 16'h3, 4'h5, 3'h4, 8'h08},
    '{48'h0000_0000_0001, 16'h8808, 16'h8, 4'h1, 3'h1, 8'h95},
    '{48'h4433_2211_0002, 16'h8100, 16'h2, 4'h1, 3'h0, 8'h21},
    '{48'hFFFF_FFFF_FFFF, 16'h8808, 16'h1, 4'h8, 3'h0, 8'h07}};

  txfsv_top #(.PFC_EN(1'b1)) i_dut (
    .core_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hrdy), .hwdata_in(hwdata), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(hresp), .tx_beat_in(beat), .tx_stats_vector_out(vec),
    .tx_stats_valid_out(vld), .irq_out(irq));

  txfsv_client #(.VEC_W(27)) i_client (
    .core_clk_in(clk), .rst_in(rst), .vec_in(vec), .valid_in(vld), .frames_out(frames), .bytes_out(nbytes));

  // ============================================================
  // clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // single ahb-lite word transfer, read data left in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1 && ++n < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1 && ++n < 50);
    rd = hrdata;
    chk(hresp, 1'b0);
    if (n >= 50) num_errors++;
  endtask

  // send one frame as beats, then check its statistics
  task automatic frame(input txfsv_row_s r);
    int          l;
    int          n;
    logic [14:0] el;
    l  = (r.nb - 1) * 8 + r.lb;
    el = (l > 32767) ? LEN_MAX : l[14:0];
    @(posedge clk);
    for (int i = 0; i < r.nb; i++)
    begin
      beat <= {1'b1, i == 0, i == r.nb - 1, (i == r.nb - 1) ? r.lb : BEAT_BYTES,
               (i == 0) ? {16'h0, r.da} : (i == 1) ? {16'h0, r.ty[7:0], r.ty[15:8], 32'h0} : 64'h0, r.fx};
      @(posedge clk);
    end
    beat <= '0;
    sent += l;
    nfr++;
    n = 0;
    while (vld !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(vld, 1'b1);
    chk({vec[26:25], vec[20:0]}, {r.fl[7:5], el, r.fl[4:0]});
    @(posedge clk);
    #1;
    chk(vld, 1'b0);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    #200000;
    num_errors++;
    print_verdict();
  end

  // ============================================================
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    ahb(1'b0, REG_CTRL, 32'h0);
    chk(rd, {31'h0, CTRL_RST});
    ahb(1'b0, REG_MASK, 32'h0);
    chk(rd, {29'h0, MASK_RST});
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, REG_CTRL, 32'h1);
    ahb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h1);
    $display("test registers done");
    foreach (rows[i]) frame(rows[i]);
    chk(irq, 1'b0);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h7);
    $display("test frame table done");
    // tag ignored with vlan handling off, then a jumbo frame
    ahb(1'b1, REG_CTRL, 32'h0);
    frame('{48'h4433_2211_0002, 16'h8100, 16'h2, 4'h1, 3'h0, 8'h01});
    frame('{48'h4433_2211_0002, 16'h0800, 16'd4097, 4'h8, 3'h0, 8'h01});
    $display("test vlan off and saturation done");
    // unmasking a pending event raises the line, a status read drops it
    ahb(1'b1, REG_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    $display("test interrupt done");
    chk(frames, nfr);
    chk(nbytes, sent);
    ahb(1'b0, REG_FRAME_CNT, 32'h0);
    chk(rd, nfr);
    $display("test totals done");
    // reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk({vec, vld, irq, hrdy}, 30'h1);
    rst <= 1'b0;
    ahb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    print_verdict();
  end
endmodule
